// ==== include/hbh_pkg.sv ====
// package: constants and types for the host bus handshake pin block
package hbh_pkg;

  // ********************************************************************
  // bus variants
  // ********************************************************************
  typedef enum logic [1:0] {
    HBH_BUS_GENERIC,
    HBH_BUS_STROBE_ACK,
    HBH_BUS_ENABLE_CLK
  } hbh_bus_t;

  // ********************************************************************
  // timing and reset values
  // ********************************************************************
  localparam int HBH_CLK_HZ = 20000000;
  // internal access time per transfer, in ns
  localparam int HBH_ACCESS_NS = 200;
  localparam int HBH_ACCESS_CYC = (HBH_ACCESS_NS * (HBH_CLK_HZ / 1000000) + 999) / 1000;
  localparam int HBH_DATA_W = 8;
  localparam logic [HBH_DATA_W-1:0] HBH_DATA_RST = 8'h00;
  localparam logic HBH_WAIT_IDLE_N = 1'b1;   // inactive level of wait_n
  localparam logic HBH_ACK_BUSY = 1'b1;      // ack level that inserts wait states

endpackage : hbh_pkg

// ==== verilog/hbh_busy_timer.sv ====
// file: down counter that times one internal access
module hbh_busy_timer
  import hbh_pkg::*;
#(
  parameter int CYCLES = HBH_ACCESS_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  output logic done
);

  typedef struct packed {
    logic [7:0] cnt;
    logic run;
    logic done;
  } hbh_tmr_t;

  hbh_tmr_t st_r;
  hbh_tmr_t st_nxt;

  // ********************************************************************
  // count down, pulse done when it reaches zero
  // ********************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start) begin
      st_nxt.cnt = 8'(CYCLES - 1);
      st_nxt.run = 1'b1;
    end else if (st_r.run) begin
      if (st_r.cnt == 8'h00) begin
        st_nxt.run = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;

endmodule : hbh_busy_timer

// ==== verilog/hbh_host_port.sv ====
// file: handshake, strobe and reset logic of the parallel host port
//
// Contract
// - generic bus pulls wait_n low during a transfer and drives it high when done.
// - after the generic transfer ends and wait_n was driven high, the pin is released.
// - in indirect mode the host may use wait_n as a handshake before the next access.
// - strobe-and-ack bus holds xfer_ack_out high while busy and low when done.
// - after the strobe-and-ack transfer completes the ack pin is released.
// - in indirect mode the host may pace accesses with xfer_ack_out.
// - on the strobe-and-ack bus cycles are qualified by addr_strobe_n from the host.
// - while reset is low all registers take defaults and every output goes inactive.
// - generic bus write data is captured on the rising edge of the write strobe.
module hbh_host_port
  import hbh_pkg::*;
#(
  parameter int DATA_W = HBH_DATA_W,
  parameter int ACCESS_CYC = HBH_ACCESS_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [1:0] bus_sel,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic addr_strobe_n,
  input wire logic [DATA_W-1:0] host_data,
  input wire logic scan_mode_pin,
  input wire logic test_mode_pin,
  output logic wait_o,
  output logic wait_oe,
  output logic [DATA_W-1:0] wr_data,
  output logic wr_data_vld
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY,
    ST_DONE
  } hbh_state_t;

  typedef struct packed {
    hbh_state_t state;
    logic wr_n_d;
    logic rd_n_d;
    logic tmr_start;
    logic wait_o;
    logic wait_oe;
    logic [DATA_W-1:0] wr_data;
    logic wr_data_vld;
  } hbh_port_t;

  hbh_port_t st_r;
  hbh_port_t st_nxt;
  // decoded variant and strobe edges, from the current pin levels and the strobe levels registered a cycle earlier
  logic tmr_done;
  logic cyc_ok;
  logic wr_rise;
  logic rd_fall;
  logic wr_fall;
  logic is_gen;
  logic is_ack;

  // ********************************************************************
  // cycle qualification
  // ********************************************************************
  assign is_gen = (hbh_bus_t'(bus_sel) == HBH_BUS_GENERIC);
  assign is_ack = (hbh_bus_t'(bus_sel) == HBH_BUS_STROBE_ACK);
  // test pins are expected low; if not, no transfer starts and wait_n stays undriven, though write data is still captured
  assign cyc_ok = !cs_n && !scan_mode_pin && !test_mode_pin
                  && (!is_ack || !addr_strobe_n);
  assign wr_rise = wr_n && !st_r.wr_n_d;
  assign wr_fall = !wr_n && st_r.wr_n_d;
  assign rd_fall = !rd_n && st_r.rd_n_d;

  // the timer's done pulse ends the wait state after the internal access time
  hbh_busy_timer #(
    .CYCLES(ACCESS_CYC)
  ) u_tmr (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(st_r.tmr_start),
    .done(tmr_done)
  );

  // ********************************************************************
  // transfer sequencer and pin drive
  // ********************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_n_d = wr_n;
    st_nxt.rd_n_d = rd_n;
    st_nxt.tmr_start = 1'b0;
    st_nxt.wr_data_vld = 1'b0;
    // data latched at the end of the write strobe
    if (is_gen && !cs_n && wr_rise) begin
      st_nxt.wr_data = host_data;
      st_nxt.wr_data_vld = 1'b1;
    end
    case (st_r.state)
      ST_IDLE: begin
        st_nxt.wait_oe = 1'b0;
        if ((is_gen || is_ack) && cyc_ok && (wr_fall || rd_fall)) begin
          st_nxt.state = ST_BUSY;
          st_nxt.tmr_start = 1'b1;
          st_nxt.wait_oe = 1'b1;
          // generic pulls low, strobe-and-ack drives its busy level high
          st_nxt.wait_o = is_ack ? HBH_ACK_BUSY : !HBH_WAIT_IDLE_N;
        end
      end
      ST_BUSY: begin
        // the completion level is what the host paces indirect accesses on
        if (tmr_done) begin
          st_nxt.state = ST_DONE;
          st_nxt.wait_o = is_ack ? !HBH_ACK_BUSY : HBH_WAIT_IDLE_N;
        end
      end
      ST_DONE: begin
        // completion level stands until the strobe ends, then the pin lets go
        if (wr_n && rd_n) begin
          st_nxt.state = ST_IDLE;
          st_nxt.wait_oe = 1'b0;
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
    // no drive outside chip select or on the enable-clocked bus; a chip select
    // dropped mid-access leaves the timer running, only the pin lets go
    if (cs_n || !(is_gen || is_ack)) begin
      st_nxt.wait_oe = 1'b0;
      if (st_r.state == ST_DONE) begin
        st_nxt.state = ST_IDLE;
      end
    end
  end

  // ********************************************************************
  // registers, synchronous reset
  // ********************************************************************
  // reset puts the strobe history at its idle level: a strobe still low
  // when reset ends reads as a fresh edge, so hosts release it during reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r.state <= ST_IDLE;
      st_r.wr_n_d <= 1'b1;
      st_r.rd_n_d <= 1'b1;
      st_r.tmr_start <= 1'b0;
      st_r.wait_o <= HBH_WAIT_IDLE_N;
      st_r.wait_oe <= 1'b0;
      st_r.wr_data <= DATA_W'(HBH_DATA_RST);
      st_r.wr_data_vld <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // pins come straight from the state register
  assign wait_o = st_r.wait_o;
  assign wait_oe = st_r.wait_oe;
  assign wr_data = st_r.wr_data;
  assign wr_data_vld = st_r.wr_data_vld;

  // ********************************************************************
  // checks
  // ********************************************************************
  sequence s_start;
    st_r.state == ST_IDLE && st_nxt.state == ST_BUSY;
  endsequence

  // completion step while the pin is driven with chip select present
  sequence s_done;
    st_r.state == ST_BUSY && tmr_done && !cs_n && wait_oe;
  endsequence

  // busy step that must keep the wait level unchanged
  sequence s_busy_hold;
    st_r.state == ST_BUSY && !tmr_done && !cs_n && wait_oe;
  endsequence

  // cycles from the start edge to the edge that samples the completion state
  localparam int DONE_LAG = ACCESS_CYC + 3;

  chk_drive_needs_cs: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(cs_n) |-> !wait_oe) else $error("wait pin driven without chip select");
  chk_gen_wait_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_start and is_gen) |=> (wait_oe && !wait_o)) else $error("generic wait not low");
  chk_ack_busy_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_start and is_ack) |=> (wait_oe && wait_o)) else $error("ack not busy high");
  chk_release_after: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_r.state == ST_DONE && st_nxt.state == ST_IDLE) |=> !wait_oe)
    else $error("pin not released after transfer");
  chk_done_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_r.state == ST_DONE && wait_oe) |-> (wait_o == is_gen))
    else $error("wrong completion level");
  chk_strobe_qual: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_start and is_ack) |-> !addr_strobe_n) else $error("cycle without address strobe");
  chk_wr_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (is_gen && !cs_n && wr_rise) |=> (wr_data_vld && wr_data == $past(host_data)))
    else $error("write data not captured");
  chk_reset_quiet: assert property (@(posedge ref_clk)
    !rst_b |=> (!wait_oe && !wr_data_vld)) else $error("outputs active after reset");

  // completion and hold levels of each handshake variant
  chk_gen_done_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_done and is_gen) |=> (wait_oe && wait_o)) else $error("generic completion not high");
  chk_ack_done_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_done and is_ack) |=> (wait_oe && !wait_o)) else $error("ack completion not low");
  chk_busy_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_busy_hold |=> (wait_oe && wait_o == $past(wait_o))) else $error("busy level moved");
  chk_done_on_time: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_start |-> ##DONE_LAG (st_r.state == ST_DONE)) else $error("access completed late");
  // no drive on the enable-clocked bus, nor on the ack bus without its address strobe
  chk_enclk_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!is_gen && !is_ack) |=> !wait_oe) else $error("pin driven on the enable-clocked bus");
  chk_ack_no_strobe: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_r.state == ST_IDLE && is_ack && addr_strobe_n) |=> !wait_oe)
    else $error("ack cycle started without address strobe");

endmodule : hbh_host_port

// ==== testbench/hbh_host_model.sv ====
// host-side model that masters the parallel bus
module hbh_host_model (
  input wire logic clk,
  input wire logic [1:0] bus_sel,
  input wire logic wait_o,
  input wire logic wait_oe,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic as_n,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // bus cycles
  // ****************
  // idle bus: strobes high, address strobe high
  initial begin
    {cs_n, wr_n, rd_n, as_n} = 4'hF;
    data = 8'h00;
  end

  // one access; seen = {busy shown, done shown, pin released}
  task xfer(input logic wr, input logic use_as, input logic [7:0] d,
            output logic [2:0] seen);
    int n;
    logic done_lvl;
    done_lvl = (bus_sel == 2'h0);
    seen = 3'h0;
    @(negedge clk);
    data = d;
    cs_n = 1'b0;
    as_n = ~use_as;
    wr_n = ~wr;
    rd_n = wr;
    repeat (2) @(negedge clk);
    seen[2] = (wait_oe === 1'b1) && (wait_o === ~done_lvl);
    // bounded wait: on the enable-clocked bus, or on the ack bus without the address strobe, the pin is ignored
    for (n = 0; n < 20 && !seen[1]; n++) begin
      @(negedge clk);
      seen[1] = (wait_oe === 1'b1) && (wait_o === done_lvl);
    end
    {wr_n, rd_n} = 2'h3;
    @(negedge clk);
    {cs_n, as_n} = 2'h3;
    repeat (2) @(negedge clk);
    seen[0] = (wait_oe === 1'b0);
  endtask : xfer

  // opens a generic read and leaves it pending
  task xfer_hold;
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (2) @(negedge clk);
  endtask : xfer_hold

  // ends a pending read: strobe first, chip select one cycle later
  task xfer_release;
    rd_n = 1'b1;
    @(negedge clk);
    cs_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : xfer_release

  // chip select dropped while the pin is driven; seen = {driven, released}
  task xfer_cut(output logic [1:0] seen);
    xfer_hold();
    seen[1] = (wait_oe === 1'b1);
    cs_n = 1'b1;
    @(negedge clk);
    seen[0] = (wait_oe === 1'b0);
    rd_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : xfer_cut
endmodule : hbh_host_model

// ==== testbench/test_hbh_host_port.sv ====
// self-checking bench for the host bus handshake pins
module test_hbh_host_port import hbh_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_b, cs_n, wr_n, rd_n, as_n, wait_o, wait_oe, wr_data_vld;
  logic [1:0] bus_sel;
  logic [7:0] data, wr_data, seed;
  logic [2:0] seen;
  logic use_as, drv;
  logic [7:0] exp_q[$];
  int bad_count, checks, cyc;

  hbh_host_port #(.ACCESS_CYC(HBH_ACCESS_CYC)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .bus_sel(bus_sel), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr_strobe_n(as_n),
    .host_data(data), .scan_mode_pin(1'b0), .test_mode_pin(1'b0),
    .wait_o(wait_o), .wait_oe(wait_oe), .wr_data(wr_data), .wr_data_vld(wr_data_vld));
  hbh_host_model host (.clk(ref_clk), .bus_sel(bus_sel), .wait_o(wait_o),
    .wait_oe(wait_oe), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .as_n(as_n), .data(data));

  // ****************
  // helpers
  // ****************
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string nm);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // clock and a hang limit far above the few hundred cycles needed
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  // captured data is matched against the oldest queued write
  always @(negedge ref_clk) begin
    if (rst_b === 1'b1 && wr_data_vld === 1'b1) begin
      chk(wr_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX, "write data");
    end
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    bus_sel = 2'h0;
    seed = 8'h35;
    rst_b = 1'b0; // supply is steady while reset is applied
    repeat (10) @(negedge ref_clk);
    chk({5'h00, wait_oe, wait_o, wr_data_vld}, 8'h02, "reset pins");
    chk(wr_data, 8'h00, "reset data");
    rst_b = 1'b1;
    // each variant: write, read, write; the last strobe-ack write lacks its strobe
    for (int b = 0; b < 3; b++) begin
      bus_sel = b[1:0];
      for (int k = 0; k < 3; k++) begin
        seed = lfsr(seed);
        use_as = (b == 1) && (k != 2);
        drv = (b == 0) || use_as;
        if (b == 0 && k != 1) exp_q.push_back(seed);
        host.xfer(k != 1, use_as, seed, seen);
        chk(8'(seen[2]), 8'(drv), "busy level");
        chk(8'(seen[1]), 8'(drv), "done level");
        chk(8'(seen[0]), 8'h01, "released");
      end
    end
    // chip select cut in mid access, then a reset in mid access
    bus_sel = 2'h0;
    host.xfer_cut(seen[1:0]);
    chk(8'(seen[1]), 8'h01, "cut driven");
    chk(8'(seen[0]), 8'h01, "cut released");
    host.xfer_hold();
    chk(8'(wait_oe), 8'h01, "held access");
    rst_b = 1'b0;
    host.xfer_release();
    chk({5'h00, wait_oe, wait_o, wr_data_vld}, 8'h02, "mid reset pins");
    chk(wr_data, 8'h00, "mid reset data");
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(8'(exp_q.size()), 8'h00, "pending writes");
    stop_test();
  end
endmodule : test_hbh_host_port
